/* File: vr_fault_cfg.svh */
// constants for the regulator fault supervisor
`ifndef VR_FAULT_CFG_SVH
`define VR_FAULT_CFG_SVH

// clock period in picoseconds (250 MHz)
`define CLK_PERIOD_PS          4000
// response limit for forcing pwm low or hi-z, in picoseconds
`define PWM_FORCE_LIMIT_PS     20000
// longest time rounds down, at least one cycle
`define PWM_FORCE_CYCLES       ((`PWM_FORCE_LIMIT_PS / `CLK_PERIOD_PS) < 1 ? \
                                1 : (`PWM_FORCE_LIMIT_PS / `CLK_PERIOD_PS))
// consecutive switching cycles for per-channel overcurrent
`define CHAN_OC_CYCLES         8
// switching cycles of overcurrent hiccup wait
`define OC_WAIT_CYCLES         4096
// switching cycles from off code to shutdown
`define OFF_CODE_DELAY         2
// switching cycles of power good release delay
`define PG_DELAY_CYCLES        16
// the two latched off identification codes
`define VID_OFF_CODE_A         6'h3F
`define VID_OFF_CODE_B         6'h3E

`endif

/* File: vr_fault_pkg.sv */
// types for the regulator fault supervisor
package vr_fault_pkg;

    // supervisor sequencing state
    typedef enum logic [2:0]
    {
        ST_SHUTDOWN,
        ST_SOFTSTART,
        ST_PG_DELAY,
        ST_RUN,
        ST_OC_WAIT,
        ST_LATCH_OFF
    } sup_state_t;

    // pwm output command to the phase drivers
    typedef enum logic [1:0]
    {
        PWM_HIZ,
        PWM_LOW,
        PWM_NORMAL
    } pwm_cmd_t;

endpackage

/* File: vr_fault_supervisor.sv */
// fault supervisor: power good, ovp, ocp hiccup, thermal alerts
// Functional notes
// - power good low in shutdown; high after soft-start plus fixed delay.
// - power good low on uv, ov, disable, reset or off code.
// - undervoltage below sixty percent of code voltage drops power good.
// - overvoltage protection armed from end of reset, enabled or not.
// - ov trip 1.275V until valid code, then code voltage plus 175mV.
// - on ov, pwm low within 20ns until diff sense below 0.4V, then hi-z.
// - each recurrence of overvoltage drives pwm low again.
// - ov latches off; only enable or supply cycling clears; codes do not.
// - average current above reference trips overcurrent immediately.
// - channel above reference eight consecutive cycles in run state trips overcurrent.
// - overcurrent puts pwm hi-z within 20ns for 4096 switching cycles.
// - after wait, restart soft-start while enabled; repeat indefinitely.
// - thermal alerts are open-drain; system supplies pull-ups.
// - cooling request released below 33%, pulled low above 39%.
// - overtemp alert released below 28%, pulled low above 33%.
// - shutdown holds all pwm outputs in hi-z unless overvoltage pulls them low.
// - off code waits two switching cycles, then shuts down pwm and ov level.
// - off codes latch; cleared only by reset or enable cycling.
`timescale 1ns/1ns
`include "vr_fault_cfg.svh"
`default_nettype none

module vr_fault_supervisor #(
    parameter int          NUM_PHASES   = 4,
    parameter int unsigned OC_WAIT      = `OC_WAIT_CYCLES,
    parameter int unsigned PG_DELAY     = `PG_DELAY_CYCLES
)(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  sw_tick,
    input  wire logic                  power_rail_enable_in,
    input  wire logic                  termination_rail_enable_in,
    input  wire logic [5:0]            voltage_ident_code,
    input  wire logic                  softstart_done_in,
    input  wire logic                  uv_below_60pct_in,
    input  wire logic                  ov_above_boot_in,
    input  wire logic                  ov_above_vid_in,
    input  wire logic                  diff_sense_below_0v4_in,
    input  wire logic                  avg_oc_in,
    input  wire logic [NUM_PHASES-1:0] chan_oc_in,
    input  wire logic                  tm_below_28pct_in,
    input  wire logic                  tm_below_33pct_in,
    input  wire logic                  tm_above_33pct_in,
    input  wire logic                  tm_above_39pct_in,
    output logic                       softstart_run,
    output logic                       ov_level_vid,
    output logic [NUM_PHASES-1:0]      pwm_low_out,
    output logic [NUM_PHASES-1:0]      pwm_drive_oe,
    output logic                       power_good_out,
    output logic                       power_good_oe,
    output logic                       regulator_cooling_request,
    output logic                       regulator_cooling_oe,
    output logic                       regulator_overtemp_alert,
    output logic                       regulator_overtemp_oe,
    output logic                       ov_latched,
    output logic                       oc_active
);

    // ************************************************************
    // enables, off code and overvoltage latch
    // ************************************************************
    vr_fault_pkg::sup_state_t state_reg;
    logic        enabled;
    logic        off_code;
    logic        off_latched_reg;
    logic [1:0]  off_cnt_reg;
    logic        ov_trip;
    logic        ov_latch_reg;
    logic        ov_pull_low_reg;
    logic        vid_valid_reg;
    logic [12:0] oc_cnt_reg;
    logic [3:0]  chan_run_reg [NUM_PHASES];
    logic [NUM_PHASES-1:0] chan_trip;
    logic        oc_trip;
    logic [15:0] pg_cnt_reg;

    assign enabled  = power_rail_enable_in & termination_rail_enable_in;
    assign off_code = (voltage_ident_code == `VID_OFF_CODE_A) |
                      (voltage_ident_code == `VID_OFF_CODE_B);

    // ov level tracks the code only once a valid code was seen
    // ov trip level select
    assign ov_trip = vid_valid_reg ? ov_above_vid_in : ov_above_boot_in;

    // valid code seen while enabled; reset with the enables
    always_ff @(posedge clk)
    begin
        if (rst || !enabled)
            vid_valid_reg <= 1'b0;
        else if (off_latched_reg)
            vid_valid_reg <= 1'b0;
        else if (!off_code)
            vid_valid_reg <= 1'b1;
    end

    // off code latch: two switching cycles, then held until re-enable
    // two tick delay on off code
    always_ff @(posedge clk)
    begin
        if (rst || !enabled)
        begin
            off_latched_reg <= 1'b0;
            off_cnt_reg     <= 2'h0;
        end
        else if (!off_latched_reg)
        begin
            if (!off_code)
                off_cnt_reg <= 2'h0;
            else if (sw_tick)
            begin
                if (off_cnt_reg == 2'(`OFF_CODE_DELAY - 1))
                    off_latched_reg <= 1'b1;
                else
                    off_cnt_reg <= off_cnt_reg + 2'h1;
            end
        end
    end

    // ovp works in any state once reset is over; only reset or enable clears it
    // ovp always armed
    // ov latch cleared by reset or enable only
    always_ff @(posedge clk)
    begin
        if (rst || !enabled)
            ov_latch_reg <= 1'b0;
        else if (ov_trip)
            ov_latch_reg <= 1'b1;
    end

    // pull low on each ov occurrence, release to hi-z below 0.4V
    // low then hi-z
    always_ff @(posedge clk)
    begin
        if (rst)
            ov_pull_low_reg <= 1'b0;
        else if (ov_trip)
            ov_pull_low_reg <= 1'b1;
        else if (diff_sense_below_0v4_in)
            ov_pull_low_reg <= 1'b0;
    end

    // ************************************************************
    // overcurrent detection
    // ************************************************************
    // per-channel run counters advance on switching ticks only
    // eight consecutive cycles
    genvar g;
    generate
        for (g = 0; g < NUM_PHASES; g = g + 1)
        begin : g_chan
            always_ff @(posedge clk)
            begin
                if (rst || !chan_oc_in[g] || state_reg != vr_fault_pkg::ST_RUN)
                    chan_run_reg[g] <= 4'h0;
                else if (sw_tick && chan_run_reg[g] != 4'(`CHAN_OC_CYCLES))
                    chan_run_reg[g] <= chan_run_reg[g] + 4'h1;
            end
            assign chan_trip[g] = (chan_run_reg[g] == 4'(`CHAN_OC_CYCLES));
        end
    endgenerate

    assign oc_trip = avg_oc_in | (|chan_trip);

    // ************************************************************
    // sequencing
    // ************************************************************
    // hiccup wait and power good delay share the sequencer
    // retry after wait
    always_ff @(posedge clk)
    begin
        if (rst || !enabled)
        begin
            state_reg  <= vr_fault_pkg::ST_SHUTDOWN;
            oc_cnt_reg <= 13'h0000;
            pg_cnt_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                vr_fault_pkg::ST_SHUTDOWN:
                    if (ov_latch_reg || off_code || off_latched_reg)
                        state_reg <= vr_fault_pkg::ST_LATCH_OFF;
                    else
                        state_reg <= vr_fault_pkg::ST_SOFTSTART;
                vr_fault_pkg::ST_SOFTSTART, vr_fault_pkg::ST_PG_DELAY,
                vr_fault_pkg::ST_RUN:
                begin
                    if (ov_trip || ov_latch_reg || off_latched_reg)
                        state_reg <= vr_fault_pkg::ST_LATCH_OFF;
                    else if (oc_trip)
                    begin
                        state_reg  <= vr_fault_pkg::ST_OC_WAIT;
                        oc_cnt_reg <= 13'h0000;
                    end
                    else if (state_reg == vr_fault_pkg::ST_SOFTSTART &&
                             softstart_done_in)
                    begin
                        state_reg  <= vr_fault_pkg::ST_PG_DELAY;
                        pg_cnt_reg <= 16'h0000;
                    end
                    else if (state_reg == vr_fault_pkg::ST_PG_DELAY &&
                             sw_tick)
                    begin
                        if (pg_cnt_reg == 16'(PG_DELAY - 1))
                            state_reg <= vr_fault_pkg::ST_RUN;
                        else
                            pg_cnt_reg <= pg_cnt_reg + 16'h0001;
                    end
                end
                vr_fault_pkg::ST_OC_WAIT:
                    if (ov_trip || ov_latch_reg || off_latched_reg)
                        state_reg <= vr_fault_pkg::ST_LATCH_OFF;
                    else if (sw_tick)
                    begin
                        if (oc_cnt_reg == 13'(OC_WAIT - 1))
                            state_reg <= vr_fault_pkg::ST_SOFTSTART;
                        else
                            oc_cnt_reg <= oc_cnt_reg + 13'h0001;
                    end
                vr_fault_pkg::ST_LATCH_OFF:
                    state_reg <= vr_fault_pkg::ST_LATCH_OFF;
                default:
                    state_reg <= vr_fault_pkg::ST_SHUTDOWN;
            endcase
        end
    end

    // ************************************************************
    // outputs, all registered
    // ************************************************************
    // pwm: ov low beats everything; hi-z in every state otherwise, run included
    // hi-z in shutdown
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwm_low_out  <= '0;
            pwm_drive_oe <= '0;
        end
        else if (ov_trip || ov_pull_low_reg)
        begin
            pwm_low_out  <= '1;
            pwm_drive_oe <= '1;
        end
        else
        begin
            pwm_low_out  <= '0;
            pwm_drive_oe <= '0;
        end
    end

    // power good open drain: oe high pulls the pin low
    // low on faults or disable
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            power_good_out <= 1'b0;
            power_good_oe  <= 1'b1;
        end
        else if (state_reg == vr_fault_pkg::ST_RUN && enabled &&
                 !uv_below_60pct_in && !ov_trip && !off_latched_reg &&
                 !oc_trip)
        begin
            power_good_out <= 1'b0;
            power_good_oe  <= 1'b0;
        end
        else
        begin
            power_good_out <= 1'b0;
            power_good_oe  <= 1'b1;
        end
    end

    // status and handshake outputs to the analog side
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            softstart_run <= 1'b0;
            ov_level_vid  <= 1'b0;
            ov_latched    <= 1'b0;
            oc_active     <= 1'b0;
        end
        else
        begin
            softstart_run <= (state_reg == vr_fault_pkg::ST_SOFTSTART);
            ov_level_vid  <= vid_valid_reg;
            ov_latched    <= ov_latch_reg;
            oc_active     <= (state_reg == vr_fault_pkg::ST_OC_WAIT);
        end
    end

    // thermal comparators with hysteresis; oe high pulls low
    // open-drain alerts
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            regulator_cooling_oe  <= 1'b1;
            regulator_overtemp_oe <= 1'b1;
        end
        else
        begin
            if (tm_below_33pct_in)
                regulator_cooling_oe <= 1'b0;
            else if (tm_above_39pct_in)
                regulator_cooling_oe <= 1'b1;
            if (tm_below_28pct_in)
                regulator_overtemp_oe <= 1'b0;
            else if (tm_above_33pct_in)
                regulator_overtemp_oe <= 1'b1;
        end
    end

    // open drain pins never drive high
    always_ff @(posedge clk)
    begin
        regulator_cooling_request <= 1'b0;
        regulator_overtemp_alert  <= 1'b0;
    end

    // ************************************************************
    // checks
    // ************************************************************
    // pwm low quickly after ov
    chk_ov_pwm_low: assert property (@(posedge clk) disable iff (rst)
        ov_trip |=> (pwm_low_out == '1 && pwm_drive_oe == '1))
        else $error("pwm not low after overvoltage");
    // release to hi-z after low sense
    chk_ov_release_hiz: assert property (@(posedge clk) disable iff (rst)
        (!ov_trip && diff_sense_below_0v4_in) ##1 !ov_trip |=>
        pwm_drive_oe == '0)
        else $error("pwm not hi-z after diff sense low");
    chk_ov_latch_hold: assert property (@(posedge clk) disable iff (rst)
        (ov_latch_reg && enabled) |=> ov_latch_reg)
        else $error("ov latch lost while enabled");
    chk_avg_oc_trip: assert property (@(posedge clk) disable iff (rst)
        (state_reg == vr_fault_pkg::ST_RUN && avg_oc_in && enabled &&
         !ov_trip && !ov_latch_reg && !off_latched_reg) |=>
        state_reg == vr_fault_pkg::ST_OC_WAIT)
        else $error("no overcurrent shutdown");
    chk_oc_hiz: assert property (@(posedge clk) disable iff (rst)
        (state_reg == vr_fault_pkg::ST_OC_WAIT && !ov_trip &&
         !ov_pull_low_reg) |=> pwm_drive_oe == '0)
        else $error("pwm driven during overcurrent wait");
    chk_pg_disable: assert property (@(posedge clk) disable iff (rst)
        !enabled |=> power_good_oe)
        else $error("power good released while disabled");
    chk_pg_uv: assert property (@(posedge clk) disable iff (rst)
        uv_below_60pct_in |=> power_good_oe)
        else $error("power good released under undervoltage");
    chk_cool_release: assert property (@(posedge clk) disable iff (rst)
        tm_below_33pct_in |=> !regulator_cooling_oe)
        else $error("cooling request not released");
    chk_hot_pull: assert property (@(posedge clk) disable iff (rst)
        (tm_above_33pct_in && !tm_below_28pct_in) |=> regulator_overtemp_oe)
        else $error("overtemp alert not pulled low");

    cov_pg_release: cover property (@(posedge clk) disable iff (rst)
        power_good_oe ##1 !power_good_oe);
    cov_oc_retry: cover property (@(posedge clk) disable iff (rst)
        state_reg == vr_fault_pkg::ST_OC_WAIT ##1
        state_reg == vr_fault_pkg::ST_SOFTSTART);
    cov_ov_recur: cover property (@(posedge clk) disable iff (rst)
        ov_trip ##1 !ov_trip [*2] ##1 ov_trip);

endmodule

`default_nettype wire

/* File: vr_far_side_model.sv */
// far-side model: phase drivers and the pulled-up status lines
`timescale 1ns/1ns
`default_nettype none

// ************************************************
// phase drivers and system monitor pins
// ************************************************
module vr_far_side_model (
    input  wire logic       clk,
    input  wire logic [3:0] pwm_drive_oe,
    input  wire logic [3:0] pwm_low_out,
    input  wire logic       power_good_oe,
    input  wire logic       cooling_oe,
    input  wire logic       overtemp_oe,
    output logic [3:0]      pwm_pin,
    output logic [3:0]      lower_fet_on,
    output logic            pg_pin,
    output logic            cooling_pin,
    output logic            overtemp_pin
);
    logic [3:0] float_reg = 4'h5;

    // an undriven pwm input wanders, so no one may trust a held level
    always_ff @(posedge clk)
        float_reg <= ~float_reg;

    // low pin turns lower fets on, hi-z turns drivers off
    // a set low command grounds the pin, so the lower fet conducts
    assign pwm_pin = (pwm_drive_oe & ~pwm_low_out) |
                     (~pwm_drive_oe & float_reg);
    assign lower_fet_on = pwm_drive_oe & pwm_low_out;

    // system pull-ups hold every released line high
    assign pg_pin       = power_good_oe ? 1'b0 : 1'b1;
    assign cooling_pin  = cooling_oe ? 1'b0 : 1'b1;
    assign overtemp_pin = overtemp_oe ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* File: vr_fault_supervisor_tb_top.sv */
// self-checking bench for the regulator fault supervisor
`timescale 1ns/1ns
`default_nettype none

`define CHK(w, e, g) check_val(w, 32'(e), 32'(g))
`define WAITC(c) \
    begin \
        wcnt = 0; \
        while ((c) !== 1'b1 && wcnt < 12) \
        begin \
            @(negedge clk); \
            wcnt++; \
        end \
        if ((c) !== 1'b1) \
        begin \
            mismatches++; \
            $display("BAD wait expected 1 seen 0"); \
            tally_and_finish(); \
        end \
    end

module vr_fault_supervisor_tb_top;
    localparam int NPH = 4;
    localparam int OCW = 8;
    localparam int PGD = 2;

    logic       clk = 1'b0, rst = 1'b1, sw_tick = 1'b0;
    logic       pwr_en = 1'b0, vtt_en = 1'b0, ss_done = 1'b0;
    logic [5:0] code = 6'h10;
    logic       uv = 1'b0, ov_boot = 1'b0, ov_vid = 1'b0;
    logic       diff_low = 1'b0, avg_oc = 1'b0;
    logic [3:0] chan_oc = 4'h0, chan_sel;
    logic       t28 = 1'b0, t33b = 1'b0, t33a = 1'b0, t39 = 1'b0;
    logic       ss_run, ov_lvl, pg_out, pg_oe, ov_lat, oc_act;
    logic       cool_out, cool_oe, hot_out, hot_oe;
    logic       pg_pin, cool_pin, hot_pin;
    logic [3:0] pwm_low, pwm_oe, pwm_pin, fet_on;
    int         mismatches = 0, n_compared = 0, wcnt, seed_val;
    int         exp_cool, exp_hot;
    int         tq[$] = '{35, 30, 36, 40, 34, 25, 30, 34, 45};

    // 250 MHz clock
    always #2 clk = ~clk;

    vr_fault_supervisor #(.NUM_PHASES(NPH), .OC_WAIT(OCW),
                          .PG_DELAY(PGD)) uut (
        .clk(clk), .rst(rst), .sw_tick(sw_tick),
        .power_rail_enable_in(pwr_en),
        .termination_rail_enable_in(vtt_en),
        .voltage_ident_code(code), .softstart_done_in(ss_done),
        .uv_below_60pct_in(uv), .ov_above_boot_in(ov_boot),
        .ov_above_vid_in(ov_vid), .diff_sense_below_0v4_in(diff_low),
        .avg_oc_in(avg_oc), .chan_oc_in(chan_oc),
        .tm_below_28pct_in(t28), .tm_below_33pct_in(t33b),
        .tm_above_33pct_in(t33a), .tm_above_39pct_in(t39),
        .softstart_run(ss_run), .ov_level_vid(ov_lvl),
        .pwm_low_out(pwm_low), .pwm_drive_oe(pwm_oe),
        .power_good_out(pg_out), .power_good_oe(pg_oe),
        .regulator_cooling_request(cool_out),
        .regulator_cooling_oe(cool_oe),
        .regulator_overtemp_alert(hot_out),
        .regulator_overtemp_oe(hot_oe),
        .ov_latched(ov_lat), .oc_active(oc_act));

    vr_far_side_model far (
        .clk(clk), .pwm_drive_oe(pwm_oe), .pwm_low_out(pwm_low),
        .power_good_oe(pg_oe), .cooling_oe(cool_oe),
        .overtemp_oe(hot_oe), .pwm_pin(pwm_pin), .lower_fet_on(fet_on),
        .pg_pin(pg_pin), .cooling_pin(cool_pin), .overtemp_pin(hot_pin));

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic check_val(input string w, input logic [31:0] e,
                             input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", w, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one tick every four clocks keeps tick edges clear of input changes
    task automatic tick(input int n);
        repeat (n)
        begin
            sw_tick = 1'b1;
            cyc(1);
            sw_tick = 1'b0;
            cyc(3);
        end
    endtask

    // enable with a valid code and walk soft-start into regulation
    task automatic bring_up();
        ss_done = 1'b0;
        pwr_en = 1'b1;
        vtt_en = 1'b1;
        code = 6'($urandom % 62);
        // state moves on the first edge, the status flop one edge later
        cyc(2);
        `CHK("ss_run", 1, ss_run);
        ss_done = 1'b1;
        cyc(2);
        tick(PGD - 1);
        `CHK("pg_oe held", 1, pg_oe);
        tick(1);
        `WAITC(pg_oe === 1'b0)
        `CHK("pg_pin", 1, pg_pin);
        `CHK("pg_out", 0, pg_out);
        `CHK("ov_lvl run", 1, ov_lvl);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial
    begin
        seed_val = $urandom(32'h1C16);
        cyc(4);
        rst = 1'b0;
        cyc(1);
        `CHK("pwm_oe rst", 0, pwm_oe);
        `CHK("pg_oe rst", 1, pg_oe);
        `CHK("ov_lvl rst", 0, ov_lvl);
        $display("test reset done");

        // protection armed while disabled, repeats on each recurrence
        ov_boot = 1'b1;
        cyc(1);
        `CHK("pwm_oe ov", 4'hF, pwm_oe);
        `CHK("fet_on ov", 4'hF, fet_on);
        ov_boot = 1'b0;
        diff_low = 1'b1;
        `WAITC(pwm_oe === 4'h0)
        `CHK("pwm_oe hiz", 0, pwm_oe);
        diff_low = 1'b0;
        ov_boot = 1'b1;
        cyc(1);
        `CHK("pwm_oe again", 4'hF, pwm_oe);
        ov_boot = 1'b0;
        diff_low = 1'b1;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        $display("test idle overvoltage done");

        // undervoltage and disable both drop power good
        bring_up();
        // boot level no longer trips once a valid code is seen
        ov_boot = 1'b1;
        cyc(1);
        `CHK("pwm_oe boot lvl", 0, pwm_oe);
        ov_boot = 1'b0;
        uv = 1'b1;
        cyc(1);
        `CHK("pg_oe uv", 1, pg_oe);
        uv = 1'b0;
        `WAITC(pg_oe === 1'b0)
        vtt_en = 1'b0;
        cyc(1);
        `CHK("pg_oe off", 1, pg_oe);
        bring_up();
        $display("test power good done");

        // average overcurrent: hiccup wait then retry
        avg_oc = 1'b1;
        cyc(1);
        avg_oc = 1'b0;
        ss_done = 1'b0;
        `WAITC(oc_act === 1'b1)
        `CHK("pwm_oe oc", 0, pwm_oe);
        `CHK("pg_oe oc", 1, pg_oe);
        tick(OCW - 1);
        `CHK("oc wait", 1, oc_act);
        `CHK("no retry", 0, ss_run);
        tick(1);
        `WAITC(ss_run === 1'b1)
        `CHK("oc retry", 0, oc_act);
        bring_up();
        $display("test average overcurrent done");

        // channel overcurrent: a break restarts the count
        chan_sel = 4'(1 << ($urandom % 4));
        chan_oc = chan_sel;
        tick(7);
        chan_oc = 4'h0;
        tick(1);
        chan_oc = chan_sel;
        tick(7);
        `CHK("oc early", 0, oc_act);
        tick(1);
        `WAITC(oc_act === 1'b1)
        chan_oc = 4'h0;
        ss_done = 1'b0;
        diff_low = 1'b0;
        ov_boot = 1'b1;
        ov_vid = 1'b1;
        cyc(1);
        `CHK("ov over oc", 4'hF, pwm_oe);
        ov_boot = 1'b0;
        ov_vid = 1'b0;
        diff_low = 1'b1;
        tick(OCW + 1);
        `CHK("ov no retry", 0, ss_run);
        code = 6'($urandom % 62);
        cyc(2);
        `CHK("ov latched", 1, ov_lat);
        pwr_en = 1'b0;
        `WAITC(ov_lat === 1'b0)
        bring_up();
        $display("test channel overcurrent done");

        // off codes shut down after two ticks and stay latched
        code = 6'h3F;
        tick(2);
        `WAITC(pg_oe === 1'b1)
        code = 6'h05;
        cyc(2);
        `CHK("off latched", 1, pg_oe);
        `CHK("ov_lvl off", 0, ov_lvl);
        pwr_en = 1'b0;
        code = 6'h3E;
        cyc(1);
        pwr_en = 1'b1;
        cyc(3);
        `CHK("off at enable", 0, ss_run);
        pwr_en = 1'b0;
        cyc(1);
        bring_up();
        $display("test off code done");

        // thermistor sweep against an integer hysteresis model
        exp_cool = 1;
        exp_hot = 1;
        repeat (16) tq.push_back(10 + int'($urandom % 50));
        foreach (tq[i])
        begin
            t28 = (tq[i] < 28);
            t33b = (tq[i] < 33);
            t33a = (tq[i] > 33);
            t39 = (tq[i] > 39);
            exp_cool = tq[i] < 33 ? 0 : (tq[i] > 39 ? 1 : exp_cool);
            exp_hot = tq[i] < 28 ? 0 : (tq[i] > 33 ? 1 : exp_hot);
            cyc(2);
            `CHK("cool_oe", exp_cool, cool_oe);
            `CHK("hot_oe", exp_hot, hot_oe);
            `CHK("cool_pin", exp_cool == 0, cool_pin);
            `CHK("hot_pin", exp_hot == 0, hot_pin);
            `CHK("cool_out", 0, cool_out);
            `CHK("hot_out", 0, hot_out);
        end
        $display("test thermal done");
        tally_and_finish();
    end

    // hang guard
    initial
    begin
        #200000;
        mismatches++;
        $display("BAD watchdog expected done seen hung");
        tally_and_finish();
    end
endmodule

`default_nettype wire
